/* core/omc_pkg.sv */
// shared constants and carriers for the operating mode controller
package omc_pkg;
  localparam int unsigned SYS_CLK_HZ = 25000000;
  localparam int unsigned SYS_CLK_KHZ = SYS_CLK_HZ / 1000;
  // timeouts in ms and wake settle in us, typical values
  localparam int unsigned WATCHDOG_PERIOD_MS = 310;
  localparam int unsigned INPUT_IDLE_MS = 250;
  localparam int unsigned WAKE_SETTLE_US = 50;
  localparam longint unsigned WATCHDOG_PERIOD_CYC = longint'(WATCHDOG_PERIOD_MS) * SYS_CLK_KHZ;
  localparam longint unsigned INPUT_IDLE_CYC = longint'(INPUT_IDLE_MS) * SYS_CLK_KHZ;
  localparam int unsigned WAKE_SETTLE_CYC = WAKE_SETTLE_US * (SYS_CLK_HZ / 1000000);
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned DUTY_W = 8;
  localparam int unsigned DUTY_LSB = 0;
  localparam int unsigned ON_BIT_POS = 8;
  localparam int unsigned GSR_WD_OFF_POS = 4;
  localparam logic [1:0] DEFAULT_DELAY = 2'h0;
  localparam logic [1:0] DEFAULT_SLEW = 2'h0;
  localparam logic [15:0] PULSE_WIDTH_RESET = 16'h0000;
  localparam logic [15:0] GLOBAL_SETUP_RESET = 16'h0000;

  typedef enum logic [1:0] {OMC_SLEEP, OMC_NORMAL, OMC_FAILSAFE, OMC_FAULT} omc_mode_e;

  // per-channel setting from the serial registers
  typedef struct packed {
    logic [15:0] pulse_width_reg;
    logic pwm_enable;
    logic internal_clock_sel;
    logic direct_input_disable;
    logic [1:0] turn_on_delay;
    logic [1:0] slew_rate;
  } omc_chan_cfg_s;

  // per-channel protection flags
  typedef struct packed {
    logic overcurrent;
    logic overtemperature;
    logic severe_short_circuit;
  } omc_chan_flt_s;

  // per-channel drive request toward the power stage
  typedef struct packed {
    logic target_on;
    logic [1:0] turn_on_delay;
    logic [1:0] slew_rate;
  } omc_chan_drv_s;
endpackage

/* core/omc_operating_mode_controller.sv */
// operating mode selection and channel target logic of a dual high-side switch
`timescale 1ns/10ps
module omc_operating_mode_controller
  import omc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // pins from the host
  input wire logic wake_reset_pad,
  input wire logic [1:0] gate_in_pad,
  input wire logic ext_clock_pad,
  // supplies and protection
  input wire logic logic_supply_ok,
  input wire logic [1:0] overcurrent,
  input wire logic [1:0] overtemperature,
  input wire logic [1:0] severe_short_circuit,
  input wire logic supply_too_low,
  input wire logic supply_too_high,
  input wire logic overvoltage_enable,
  // serial register contents, decoded by the serial block
  input wire omc_chan_cfg_s [1:0] chan_cfg,
  input wire logic [15:0] global_setup_reg,
  input wire logic supply_fail_enable,
  // received serial word strobe and its first bit
  input wire logic word_valid,
  input wire logic watchdog_toggle_bit,
  // channel drive and status
  output omc_chan_drv_s [1:0] chan_drv,
  output omc_mode_e mode,
  output logic normal_state_flag,
  output logic failsafe_flag,
  output logic regs_to_default,
  output logic functions_ready
);
  // three-stage synchronisers for pins
  logic [2:0] wake_sync;
  logic [2:0] gate_sync [2];
  logic [2:0] clk_sync;
  logic [2:0] vdd_sync;
  logic wake_lvl;
  logic gate_lvl0;
  logic gate_lvl1;
  logic extclk_lvl;
  logic vdd_lvl;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_sync <= 3'h0;
      gate_sync[0] <= 3'h0;
      gate_sync[1] <= 3'h0;
      clk_sync <= 3'h0;
      vdd_sync <= 3'h0;
    end else begin
      wake_sync <= {wake_sync[1:0], wake_reset_pad};
      gate_sync[0] <= {gate_sync[0][1:0], gate_in_pad[0]};
      gate_sync[1] <= {gate_sync[1][1:0], gate_in_pad[1]};
      clk_sync <= {clk_sync[1:0], ext_clock_pad};
      vdd_sync <= {vdd_sync[1:0], logic_supply_ok};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_lvl <= 1'b0;
      gate_lvl0 <= 1'b0;
      gate_lvl1 <= 1'b0;
      extclk_lvl <= 1'b0;
      vdd_lvl <= 1'b0;
    end else begin
      if (wake_sync[1] == wake_sync[2]) wake_lvl <= wake_sync[2];
      if (gate_sync[0][1] == gate_sync[0][2]) gate_lvl0 <= gate_sync[0][2];
      if (gate_sync[1][1] == gate_sync[1][2]) gate_lvl1 <= gate_sync[1][2];
      if (clk_sync[1] == clk_sync[2]) extclk_lvl <= clk_sync[2];
      if (vdd_sync[1] == vdd_sync[2]) vdd_lvl <= vdd_sync[2];
    end
  end

  logic [1:0] gate_lvl;
  logic [1:0] gate_prev;
  logic wake_prev;
  assign gate_lvl = {gate_lvl1, gate_lvl0};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gate_prev <= 2'h0;
      wake_prev <= 1'b0;
    end else begin
      gate_prev <= gate_lvl;
      wake_prev <= wake_lvl;
    end
  end

  logic wake_rise;
  logic [1:0] gate_rise;
  assign wake_rise = wake_lvl & ~wake_prev;
  assign gate_rise = gate_lvl & ~gate_prev;

  // input activity flags; a rising gate sets, long idle clears
  logic [1:0] input_active;
  logic [TIMER_W-1:0] idle_cnt [2];
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (reset) begin
        idle_cnt[c] <= '0;
        input_active[c] <= 1'b0;
      end else if (gate_lvl[c] != gate_prev[c]) begin
        idle_cnt[c] <= '0;
        if (gate_rise[c]) input_active[c] <= 1'b1;
      end else if (idle_cnt[c] >= TIMER_W'(INPUT_IDLE_CYC)) begin
        input_active[c] <= 1'b0;
      end else begin
        idle_cnt[c] <= idle_cnt[c] + TIMER_W'(1);
      end
    end
  end

  logic wake_cond;
  assign wake_cond = wake_lvl | input_active[0] | input_active[1];

  // watchdog on the toggle bit of received words
  logic watchdog_off_bit;
  logic wd_armed;
  logic wd_run;
  logic wd_last_bit;
  logic wd_timeout;
  logic [TIMER_W-1:0] wd_cnt;
  assign watchdog_off_bit = global_setup_reg[GSR_WD_OFF_POS];
  assign wd_run = wd_armed && vdd_lvl && !watchdog_off_bit && wake_lvl;

  always_ff @(posedge sys_clk) begin
    if (reset || !wake_cond) begin
      wd_armed <= 1'b0;
      wd_cnt <= '0;
      wd_last_bit <= 1'b0;
      wd_timeout <= 1'b0;
    end else if (wake_rise && vdd_lvl) begin
      wd_armed <= 1'b1;
      wd_cnt <= '0;
      wd_timeout <= 1'b0;
    end else if (wd_run) begin
      if (word_valid && watchdog_toggle_bit != wd_last_bit) begin
        wd_last_bit <= watchdog_toggle_bit;
        wd_cnt <= '0;
      end else if (wd_cnt >= TIMER_W'(WATCHDOG_PERIOD_CYC)) begin
        wd_timeout <= 1'b1; // timeout sticks; exit path lives elsewhere
      end else begin
        wd_cnt <= wd_cnt + TIMER_W'(1);
      end
    end
  end

  // logic supply loss counts only after it was once present
  logic vdd_seen;
  logic vdd_lost;
  always_ff @(posedge sys_clk) begin
    if (reset || !wake_cond) begin
      vdd_seen <= 1'b0;
      vdd_lost <= 1'b0;
    end else begin
      if (vdd_lvl) vdd_seen <= 1'b1;
      if (vdd_seen && !vdd_lvl && supply_fail_enable) vdd_lost <= 1'b1;
    end
  end

  logic failsafe_cond;
  logic fault_cond;
  assign failsafe_cond = (wd_timeout && !watchdog_off_bit) || vdd_lost;
  assign fault_cond = |overcurrent | |overtemperature | |severe_short_circuit
                    | supply_too_low | (supply_too_high & overvoltage_enable);

  omc_mode_e next_mode;
  always_comb begin
    if (!wake_cond) next_mode = OMC_SLEEP;
    else if (fault_cond) next_mode = OMC_FAULT;
    else if (failsafe_cond) next_mode = OMC_FAILSAFE;
    else next_mode = OMC_NORMAL;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode <= OMC_SLEEP;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      normal_state_flag <= 1'b0;
      failsafe_flag <= 1'b0;
    end else begin
      normal_state_flag <= (next_mode == OMC_NORMAL);
      failsafe_flag <= (next_mode == OMC_FAILSAFE);
    end
  end

  // registers held at default while asleep; settle timer after wake
  logic [15:0] settle_cnt;
  always_ff @(posedge sys_clk) begin
    if (reset || mode == OMC_SLEEP) begin
      settle_cnt <= '0;
      functions_ready <= 1'b0;
    end else if (settle_cnt >= 16'(WAKE_SETTLE_CYC)) begin
      functions_ready <= 1'b1;
    end else begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end
  assign regs_to_default = (mode == OMC_SLEEP) || (mode == OMC_FAILSAFE);

  // internal pwm: free counter compared with duty
  logic [DUTY_W-1:0] pwm_cnt;
  logic ext_prev;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwm_cnt <= '0;
      ext_prev <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + DUTY_W'(1);
      ext_prev <= extclk_lvl;
    end
  end

  // external clock: count its rising edges, so its rate sets the period
  logic [DUTY_W-1:0] ext_cnt;
  // no gap filter: a stalled external clock freezes the phase where it stopped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_cnt <= '0;
    end else if (extclk_lvl && !ext_prev) begin
      ext_cnt <= ext_cnt + DUTY_W'(1);
    end
  end

  logic direct_only;
  // pin low or failsafe: gate pins only, so a silent host cannot keep a channel on
  assign direct_only = !wake_lvl || mode == OMC_FAILSAFE;

  // per-channel target and timing choice, registered together below
  logic [1:0] target;
  logic [1:0] use_default;
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [DUTY_W-1:0] duty;
    logic [DUTY_W-1:0] phase;
    logic duty_out;
    logic on_bit;
    logic direct_term;
    logic spi_term;
    assign duty = chan_cfg[c].pulse_width_reg[DUTY_LSB +: DUTY_W];
    assign on_bit = chan_cfg[c].pulse_width_reg[ON_BIT_POS] && !direct_only;
    assign phase = chan_cfg[c].internal_clock_sel ? pwm_cnt : ext_cnt;
    assign duty_out = phase < duty;
    assign direct_term = gate_lvl[c] && (!chan_cfg[c].direct_input_disable || direct_only);
    assign spi_term = (on_bit && duty_out && chan_cfg[c].pwm_enable)
                    || (on_bit && !chan_cfg[c].pwm_enable);
    assign target[c] = (direct_term || spi_term)
                       && (mode == OMC_NORMAL || mode == OMC_FAILSAFE);
    // direct drive alone takes default timing; with spi_term also on, or the gate low, register timing unless direct_only
    assign use_default[c] = direct_only || (direct_term && !spi_term);
  end

  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (reset) begin
        chan_drv[c] <= '0;
      end else begin
        chan_drv[c].target_on <= target[c];
        if (use_default[c]) begin
          chan_drv[c].turn_on_delay <= DEFAULT_DELAY;
          chan_drv[c].slew_rate <= DEFAULT_SLEW;
        end else begin
          chan_drv[c].turn_on_delay <= chan_cfg[c].turn_on_delay;
          chan_drv[c].slew_rate <= chan_cfg[c].slew_rate;
        end
      end
    end
  end
endmodule

/* sim/omc_operating_mode_controller_properties.sv */
// assertion checker for the operating mode controller ports
`timescale 1ns/10ps
module omc_operating_mode_controller_properties
  import omc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // watched inputs
  input wire logic wake_reset_pad,
  input wire logic [1:0] gate_in_pad,
  input wire logic logic_supply_ok,
  input wire logic [1:0] overcurrent,
  input wire logic [1:0] overtemperature,
  input wire logic [1:0] severe_short_circuit,
  input wire logic supply_too_low,
  input wire logic supply_too_high,
  input wire logic supply_fail_enable,
  // watched outputs
  input wire omc_chan_drv_s [1:0] chan_drv,
  input wire omc_mode_e mode,
  input wire logic normal_state_flag,
  input wire logic failsafe_flag,
  input wire logic regs_to_default
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic quiet;
  logic [1:0] tgt;
  // over-voltage counted even when unqualified: only narrows the antecedents
  assign quiet = !(|{overcurrent, overtemperature, severe_short_circuit, supply_too_low,
    supply_too_high});
  assign tgt = {chan_drv[1].target_on, chan_drv[0].target_on};

  a_normal_flag: assert property (normal_state_flag == (mode == OMC_NORMAL))
    else $error("normal flag disagrees with mode");
  a_sleep_off: assert property ((mode == OMC_SLEEP) [*2] |-> tgt == 2'h0)
    else $error("channel on in sleep");
  a_sleep_default: assert property (mode == OMC_SLEEP |-> regs_to_default)
    else $error("registers not held default in sleep");
  a_fault_off: assert property ((mode == OMC_FAULT) [*2] |-> tgt == 2'h0)
    else $error("channel on in fault mode");
  a_failsafe_flags: assert property (mode == OMC_FAILSAFE |-> failsafe_flag)
    else $error("failsafe flag low in failsafe mode");
  a_failsafe_direct: assert property ((mode == OMC_FAILSAFE) [*2] |->
    chan_drv[0].turn_on_delay == DEFAULT_DELAY && chan_drv[0].slew_rate == DEFAULT_SLEW)
    else $error("failsafe drive not at default timing");
  a_pad_wake: assert property ($rose(wake_reset_pad) && mode == OMC_SLEEP
    ##0 (quiet && wake_reset_pad && logic_supply_ok) [*8] |-> normal_state_flag)
    else $error("pad rise did not wake");
  a_gate_wake: assert property ($rose(gate_in_pad[0]) && mode == OMC_SLEEP
    ##0 (quiet && gate_in_pad[0] && logic_supply_ok) [*8] |-> normal_state_flag)
    else $error("gate rise did not wake");
  a_fault_entry: assert property (mode == OMC_NORMAL && supply_too_low
    ##0 (supply_too_low && wake_reset_pad) [*6] |-> mode == OMC_FAULT)
    else $error("undervoltage did not give fault mode");
  a_supply_loss: assert property ($fell(logic_supply_ok) && mode == OMC_NORMAL
    ##0 (supply_fail_enable && quiet && wake_reset_pad && !logic_supply_ok) [*8]
    |-> mode == OMC_FAILSAFE)
    else $error("logic supply loss did not give failsafe");
endmodule

bind omc_operating_mode_controller omc_operating_mode_controller_properties chk (.sys_clk,
  .reset, .wake_reset_pad, .gate_in_pad, .logic_supply_ok, .overcurrent, .overtemperature,
  .severe_short_circuit, .supply_too_low, .supply_too_high, .supply_fail_enable, .chan_drv,
  .mode, .normal_state_flag, .failsafe_flag, .regs_to_default);

/* sim/omc_host_model.sv */
// host model: wake pin, gate inputs, external clock, serial word strobes
`timescale 1ns/10ps
module omc_host_model (
  // clock and bench commands
  input wire logic sys_clk,
  input wire logic wake_cmd,
  input wire logic [1:0] gate_cmd,
  // pins toward the device
  output logic wake_reset_pad,
  output logic [1:0] gate_in_pad,
  output logic ext_clock_pad,
  output logic word_valid,
  output logic watchdog_toggle_bit
);
  logic [5:0] tick = 6'h00;
  logic wake_q;
  logic [1:0] gate_q;
  initial begin
    {wake_reset_pad, gate_in_pad, ext_clock_pad, word_valid, watchdog_toggle_bit} = 6'h00;
  end
  always @(posedge sys_clk) begin
    // commands read on the edge, pins moved after it, so no race with the bench
    wake_q = wake_cmd;
    gate_q = gate_cmd;
    #1;
    wake_reset_pad = wake_q;
    gate_in_pad = gate_q;
    ext_clock_pad = tick[2];
    if (word_valid) watchdog_toggle_bit = !watchdog_toggle_bit;
    // a word every 64 cycles, far inside the watchdog period
    word_valid = wake_q && tick == 6'h3f;
    tick = tick + 6'h01;
  end
endmodule

/* sim/tb_omc_operating_mode_controller.sv */
// self-checking bench for the operating mode controller
`timescale 1ns/10ps
module tb_omc_operating_mode_controller
  import omc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wake_cmd = 1'b0;
  logic [1:0] gate_cmd = 2'h0;
  logic logic_supply_ok = 1'b1;
  logic [1:0] overcurrent = 2'h0, overtemperature = 2'h0, severe_short_circuit = 2'h0;
  logic supply_too_low = 1'b0, supply_too_high = 1'b0, overvoltage_enable = 1'b0;
  logic supply_fail_enable = 1'b0;
  logic [15:0] global_setup_reg = 16'h0000;
  omc_chan_cfg_s [1:0] chan_cfg = '0;
  wire logic wake_reset_pad, ext_clock_pad, word_valid, watchdog_toggle_bit;
  wire logic [1:0] gate_in_pad;
  omc_chan_drv_s [1:0] chan_drv;
  omc_mode_e mode;
  logic normal_state_flag, failsafe_flag, regs_to_default, functions_ready;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_on = 0;
  integer seed = 32'h987bf5e0;

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  omc_host_model host (.sys_clk, .wake_cmd, .gate_cmd, .wake_reset_pad, .gate_in_pad,
    .ext_clock_pad, .word_valid, .watchdog_toggle_bit);
  omc_operating_mode_controller dut (.sys_clk, .reset, .wake_reset_pad, .gate_in_pad,
    .ext_clock_pad, .logic_supply_ok, .overcurrent, .overtemperature, .severe_short_circuit,
    .supply_too_low, .supply_too_high, .overvoltage_enable, .chan_cfg, .global_setup_reg,
    .supply_fail_enable, .word_valid, .watchdog_toggle_bit, .chan_drv, .mode,
    .normal_state_flag, .failsafe_flag, .regs_to_default, .functions_ready);

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_mode(input omc_mode_e m);
    repeat (50) if (mode !== m) step(1);
    check(mode === m, "mode wait ran out");
    if (mode !== m) tally_and_finish;
  endtask
  // duty forced to 00, so the pwm term stays low whatever the clock source
  function automatic logic exp_on(input omc_chan_cfg_s c, input logic g);
    return (g & ~c.direct_input_disable) | (c.pulse_width_reg[8] & ~c.pwm_enable);
  endfunction
  // over one phase wrap each step lasts hold cycles; high while phase < duty
  function automatic int exp_high(input logic [DUTY_W-1:0] duty, input int hold);
    return int'(duty) * hold;
  endfunction

  initial begin
    step(6);
    reset = 1'b0;
    check(mode === OMC_SLEEP && regs_to_default === 1'b1, "not asleep");
    gate_cmd = 2'h1;
    wait_mode(OMC_NORMAL);
    check(normal_state_flag === 1'b1, "normal flag low");
    chan_cfg[1].pulse_width_reg = 16'h0100;
    step(10);
    check(chan_drv[1].target_on === 1'b0, "on bit used with pad low");
    wake_cmd = 1'b1;
    for (int i = 0; i < 40; i++) begin
      chan_cfg = $bits(chan_cfg)'({$random(seed), $random(seed)});
      for (int c = 0; c < 2; c++) begin
        chan_cfg[c].pulse_width_reg[7:0] = 8'h00;
        chan_cfg[c].internal_clock_sel = chan_cfg[c].pulse_width_reg[8];
      end
      gate_cmd = 2'($random(seed));
      global_setup_reg = 16'($random(seed));
      step(10);
      for (int c = 0; c < 2; c++) begin
        check(chan_drv[c].target_on === exp_on(chan_cfg[c], gate_cmd[c]), "target");
        if (!chan_cfg[c].pulse_width_reg[8] && exp_on(chan_cfg[c], gate_cmd[c]))
          check(chan_drv[c].turn_on_delay === DEFAULT_DELAY, "direct delay");
      end
    end
    // half duty from the internal clock, then from the host clock (8 cycles a step)
    chan_cfg[0] = '0;
    chan_cfg[0].pulse_width_reg = 16'h0180;
    chan_cfg[0].pwm_enable = 1'b1;
    chan_cfg[0].direct_input_disable = 1'b1;
    for (int s = 0; s < 2; s++) begin
      chan_cfg[0].internal_clock_sel = !s[0];
      step(10);
      n_on = 0;
      repeat (256 * (s ? 8 : 1)) begin
        step(1);
        n_on += chan_drv[0].target_on;
      end
      check(n_on == exp_high(8'h80, s ? 8 : 1), "pwm duty count");
    end
    for (int f = 0; f < 6; f++) begin
      {overcurrent[0], overtemperature[1], severe_short_circuit[0], supply_too_low} = 4'h8 >> f;
      supply_too_high = (f >= 4);
      overvoltage_enable = (f == 4);
      step(10);
      check(mode === (f < 5 ? OMC_FAULT : OMC_NORMAL), "fault mode");
      {overcurrent[0], overtemperature[1], severe_short_circuit[0], supply_too_low} = 4'h0;
      supply_too_high = 1'b0;
      wait_mode(OMC_NORMAL);
    end
    supply_fail_enable = 1'b1;
    logic_supply_ok = 1'b0;
    wait_mode(OMC_FAILSAFE);
    check(normal_state_flag === 1'b0 && regs_to_default === 1'b1, "failsafe state");
    chan_cfg[0].direct_input_disable = 1'b1;
    chan_cfg[0].pulse_width_reg[8] = 1'b1;
    for (int g = 0; g < 2; g++) begin
      gate_cmd = 2'(g);
      step(10);
      check(chan_drv[0].target_on === g[0], "failsafe direct drive");
    end
    supply_too_low = 1'b1;
    wait_mode(OMC_FAULT);
    supply_too_low = 1'b0;
    wait_mode(OMC_FAILSAFE);
    reset = 1'b1;
    {wake_cmd, gate_cmd, logic_supply_ok} = 4'h1;
    step(6);
    reset = 1'b0;
    check(mode === OMC_SLEEP, "not asleep after second reset");
    wake_cmd = 1'b1;
    wait_mode(OMC_NORMAL);
    check(functions_ready === 1'b0, "ready too early");
    step(1300);
    check(functions_ready === 1'b1 && mode === OMC_NORMAL, "not ready");
    tally_and_finish;
  end
endmodule
